/* File: core/pwr_rst_pkg.sv */
// Package for the power-on reset and sleep control block.
// Assumes a 50 MHz hclk and an AHB-Lite register port with 32-bit data.
package pwr_rst_pkg;
   localparam int unsigned CLK_MHZ             = 50;
   localparam int unsigned POR_TIME_US         = 2500;
   localparam int unsigned POR_CYCLES          = POR_TIME_US * CLK_MHZ;
   localparam int unsigned PRESCALE_DIV        = 16;
   // Register indices; the byte address is four times the index
   localparam logic [7:0]  STOP_RECOVERY_IDX   = 8'h0b;
   localparam logic [7:0]  PORT_MODE_IDX       = 8'h0c;
   localparam logic [7:0]  SLEEP_CMD_IDX       = 8'h0d;
   localparam logic [7:0]  STATUS_IDX          = 8'h0e;
   localparam logic [11:0] STOP_RECOVERY_ADDR  = {2'b00, STOP_RECOVERY_IDX, 2'b00};
   localparam logic [11:0] PORT_MODE_ADDR      = {2'b00, PORT_MODE_IDX, 2'b00};
   localparam logic [11:0] SLEEP_CMD_ADDR      = {2'b00, SLEEP_CMD_IDX, 2'b00};
   localparam logic [11:0] STATUS_ADDR         = {2'b00, STATUS_IDX, 2'b00};
   localparam int unsigned DIV16_SEL_BIT       = 0;
   localparam int unsigned STOP_DELAY_BIT      = 5;
   localparam logic [7:0]  STOP_RECOVERY_RESET = 8'h20;
   localparam int unsigned PORT_ANALOG_BIT     = 1;
   localparam logic [7:0]  PORT_MODE_RESET     = 8'h00;
   localparam int unsigned CMD_HALT_BIT        = 0;
   localparam int unsigned CMD_STOP_BIT        = 1;
   localparam logic [15:0] STOP_RESTART_VECTOR = 16'h000c;

   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_HALT  = 2'b01,
      ST_STOP  = 2'b11,
      ST_RESET = 2'b10
   } power_state_e;

   typedef struct packed {
      logic        sel;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [11:0] haddr;
   } ahb_req_s;

   typedef struct packed {
      logic power_good;
      logic watchdog_timeout;
      logic stop_recovery_event;
      logic external_reset;
   } wake_events_s;
endpackage

/* File: core/por_timer.sv */
// One-shot power-on reset delay counter.
// Assumes tick is a one-cycle enable from the dedicated RC oscillator divider.
`timescale 1ns/1ps
module por_timer #(
   parameter int unsigned CYCLES = pwr_rst_pkg::POR_CYCLES
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic trigger,
   input  wire logic tick,
   output logic      running,
   output logic      done
);
   logic [31:0] count;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         count   <= 32'h0;
         running <= 1'b1;
         done    <= 1'b0;
      end
      else if (trigger)
      begin
         // Retrigger restarts the full delay
         count   <= 32'h0;
         running <= 1'b1;
         done    <= 1'b0;
      end
      else if (running && tick)
      begin
         if (count >= CYCLES - 1)
         begin
            running <= 1'b0;
            done    <= 1'b1;
         end
         count <= count + 32'h1;
      end
      else
         done <= 1'b0;
   end
endmodule

/* File: core/prescaler.sv */
// Divide-by-N clock enable generator.
// Assumes a single hclk; output is a one-cycle pulse every DIV cycles when divide is set, high when divide is low, low while run is low.
`timescale 1ns/1ps
module prescaler #(
   parameter int unsigned DIV = pwr_rst_pkg::PRESCALE_DIV
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic divide,
   input  wire logic run,
   output logic      tick
);
   logic [$clog2(DIV)-1:0] phase;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         phase <= '0;
         tick  <= 1'b0;
      end
      else if (!run)
         tick <= 1'b0;
      else if (!divide)
      begin
         phase <= '0;
         tick  <= 1'b1;
      end
      else
      begin
         phase <= phase + ($bits(phase))'(1);
         tick  <= (phase == ($bits(phase))'(DIV - 1));
      end
   end
endmodule

/* File: core/pwr_rst_ctrl.sv */
// Contract
// RQ1: Interrupt source chosen by port three mode bit 1.
// RQ2: Digital mode takes interrupt from port three bit three pin.
// RQ3: Analog mode takes interrupt from stop-recovery source logic.
// RQ4: RC-clocked one-shot fires on power good, watchdog, or stop recovery with D5.
// RQ5: Reset delay lasts at least 2.5 ms.
// RQ6: Control bit 5 applies or skips the delay after stop recovery.
// RQ7: Halt gates the processor clock, oscillator keeps running.
// RQ8: Timers and six interrupt inputs stay active during halt.
// RQ9: Halt ends only when an enabled interrupt is serviced; the code also leaves halt on watchdog, power-good rise or external reset.
// RQ10: After the handler, execution resumes after the halt instruction.
// RQ11: Stop disables processor clock and crystal oscillator.
// RQ12: Stop ends only by watchdog, power-on, stop-recovery or external reset.
// RQ13: After stop, fetching starts at address 000CH.
// RQ14: Software places a no-op before halt or stop.
// RQ15: Control bit D0 selects divide-by-16 of system and timer clocks.
// RQ16: Stop recovery clears the divide-by-16 select bit.
// RQ17: Processor held in reset while timer runs, released after expiry.
//
// Power-on reset and sleep controller with an AHB-Lite register port.
// Assumes the core issues halt/stop commands by register write and obeys cpu_reset.
`timescale 1ns/1ps
module pwr_rst_ctrl #(
   parameter int unsigned POR_CYCLES = pwr_rst_pkg::POR_CYCLES,
   parameter int unsigned RC_DIV     = 1
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        power_good,
   input  wire logic        watchdog_timeout,
   input  wire logic        stop_recovery_event,
   input  wire logic        external_reset,
   input  wire logic        port_three_bit_three_pin,
   input  wire logic [5:0]  irq_in,
   input  wire logic [5:0]  irq_enable,
   input  wire logic        irq_serviced,
   output logic             shared_irq,
   output logic             cpu_clk_en,
   output logic             timer_clk_en,
   output logic             crystal_oscillator_en,
   output logic             cpu_reset,
   output logic             load_restart_vector,
   output logic [15:0]      restart_vector,
   output logic [5:0]       irq_active
);
   pwr_rst_pkg::power_state_e state;
   pwr_rst_pkg::ahb_req_s     req;
   logic [7:0]  stop_recovery_control;
   logic [7:0]  port_three_mode_register;
   logic        power_good_q;
   logic        stopped_recovery;
   logic        por_trigger;
   logic        por_running;
   logic        por_done;
   logic        rc_tick;
   logic        sys_tick;
   logic        halt_cmd;
   logic        stop_cmd;
   logic        wr_sleep;
   logic        stop_wake;
   logic [$clog2(RC_DIV+1)-1:0] rc_count;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] ref_addr);
      hit = (a[11:2] == ref_addr[11:2]);
   endfunction

   // Bus: zero-wait slave, register the address phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         req <= '0;
      else if (hready)
      begin
         req.sel    <= hsel && htrans[1];
         req.htrans <= htrans;
         req.hwrite <= hwrite;
         req.hsize  <= hsize;
         req.haddr  <= haddr;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // Read data registered at the address phase so it stands in the data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0;
      else if (hready && hsel && htrans[1] && !hwrite)
      begin
         if (hit(haddr, pwr_rst_pkg::STOP_RECOVERY_ADDR))
            hrdata <= {24'h0, stop_recovery_control};
         else if (hit(haddr, pwr_rst_pkg::PORT_MODE_ADDR))
            hrdata <= {24'h0, port_three_mode_register};
         else if (hit(haddr, pwr_rst_pkg::STATUS_ADDR))
            hrdata <= {27'h0, por_running, stopped_recovery, cpu_reset, state};
         else
            hrdata <= 32'h0;
      end
   end

   assign wr_sleep = req.sel && req.hwrite && hit(req.haddr, pwr_rst_pkg::SLEEP_CMD_ADDR);
   assign halt_cmd = wr_sleep && hwdata[pwr_rst_pkg::CMD_HALT_BIT];
   assign stop_cmd = wr_sleep && hwdata[pwr_rst_pkg::CMD_STOP_BIT];
   assign stop_wake = (state == pwr_rst_pkg::ST_STOP)
                      && (stop_recovery_event || watchdog_timeout || external_reset); // [RQ12]

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         stop_recovery_control <= pwr_rst_pkg::STOP_RECOVERY_RESET;
      else
      begin
         if (req.sel && req.hwrite && hit(req.haddr, pwr_rst_pkg::STOP_RECOVERY_ADDR))
            stop_recovery_control <= hwdata[7:0];
         // Hardware clear wins over a simultaneous write
         if (stop_wake)
            stop_recovery_control[pwr_rst_pkg::DIV16_SEL_BIT] <= 1'b0; // [RQ16]
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         port_three_mode_register <= pwr_rst_pkg::PORT_MODE_RESET;
      else if (req.sel && req.hwrite && hit(req.haddr, pwr_rst_pkg::PORT_MODE_ADDR))
         port_three_mode_register <= hwdata[7:0];
   end

   // Shared interrupt source selection
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         shared_irq <= 1'b0;
      else if (port_three_mode_register[pwr_rst_pkg::PORT_ANALOG_BIT]) // [RQ1]
         shared_irq <= stop_recovery_event; // [RQ3]
      else
         shared_irq <= port_three_bit_three_pin; // [RQ2]
   end

   // Interrupt inputs stay live in every power state
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq_active <= 6'h0;
      else
         irq_active <= irq_in & irq_enable; // [RQ8]
   end

   // Dedicated RC oscillator stand-in: divider tick
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rc_count <= '0;
         rc_tick  <= 1'b0;
      end
      else if (rc_count >= ($bits(rc_count))'(RC_DIV - 1))
      begin
         rc_count <= '0;
         rc_tick  <= 1'b1;
      end
      else
      begin
         rc_count <= rc_count + ($bits(rc_count))'(1);
         rc_tick  <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         power_good_q <= 1'b0;
      else
         power_good_q <= power_good;
   end

   // Brownout wake looks like a fresh power-good rise
   assign por_trigger = (power_good && !power_good_q)
                        || watchdog_timeout
                        || (stop_wake && stop_recovery_control[pwr_rst_pkg::STOP_DELAY_BIT]); // [RQ4] [RQ6]

   por_timer #(
      .CYCLES  (POR_CYCLES)
   ) u_por (
      .hclk    (hclk),
      .hresetn (hresetn),
      .trigger (por_trigger),
      .tick    (rc_tick),
      .running (por_running),
      .done    (por_done)
   ); // [RQ5]

   prescaler #(
      .DIV     (pwr_rst_pkg::PRESCALE_DIV)
   ) u_pre (
      .hclk    (hclk),
      .hresetn (hresetn),
      .divide  (stop_recovery_control[pwr_rst_pkg::DIV16_SEL_BIT]), // [RQ15]
      .run     (state != pwr_rst_pkg::ST_STOP),
      .tick    (sys_tick)
   );

   // Power state machine
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         state <= pwr_rst_pkg::ST_RESET;
      else if (por_trigger || external_reset)
         state <= pwr_rst_pkg::ST_RESET;
      else
      begin
         case (state)
            pwr_rst_pkg::ST_RESET:
               if (!por_running)
                  state <= pwr_rst_pkg::ST_RUN; // [RQ17]
            pwr_rst_pkg::ST_RUN:
               if (stop_cmd)
                  state <= pwr_rst_pkg::ST_STOP;
               else if (halt_cmd)
                  state <= pwr_rst_pkg::ST_HALT; // [RQ7]
            pwr_rst_pkg::ST_HALT:
               if (irq_serviced && |(irq_in & irq_enable))
                  state <= pwr_rst_pkg::ST_RUN; // [RQ9] [RQ10]
            pwr_rst_pkg::ST_STOP:
               if (stop_wake)
                  state <= pwr_rst_pkg::ST_RUN;
            default:
               state <= pwr_rst_pkg::ST_RESET;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         stopped_recovery <= 1'b0;
      else if (stop_wake)
         stopped_recovery <= 1'b1;
      else if (state == pwr_rst_pkg::ST_RUN)
         stopped_recovery <= 1'b0;
   end

   // Clock gating and reset outputs
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cpu_clk_en            <= 1'b0;
         timer_clk_en          <= 1'b0;
         crystal_oscillator_en <= 1'b1;
         cpu_reset             <= 1'b1;
      end
      else
      begin
         cpu_clk_en            <= sys_tick && (state == pwr_rst_pkg::ST_RUN); // [RQ7] [RQ11]
         timer_clk_en          <= sys_tick; // [RQ8]
         crystal_oscillator_en <= (state != pwr_rst_pkg::ST_STOP); // [RQ11]
         cpu_reset             <= (state == pwr_rst_pkg::ST_RESET) || por_trigger; // [RQ17]
      end
   end

   // Restart vector after stop recovery
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         load_restart_vector <= 1'b0;
         restart_vector      <= pwr_rst_pkg::STOP_RESTART_VECTOR;
      end
      else
      begin
         load_restart_vector <= stopped_recovery && (state == pwr_rst_pkg::ST_RUN); // [RQ13]
         restart_vector      <= pwr_rst_pkg::STOP_RESTART_VECTOR;
      end
   end
endmodule

/* File: test/core_model.sv */
// Behavioural stand-in for the processor core: services pending enabled irqs.
// Assumes irq_active already holds the enabled requests; DELAY sets how slowly it answers.
`timescale 1ns/1ps
module core_model #(
   parameter int unsigned DELAY = 3
) (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic [5:0] irq_active,
   input  wire logic       cpu_reset,
   output logic            irq_serviced
);
   logic [7:0] wait_cnt;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wait_cnt     <= 8'h00;
         irq_serviced <= 1'b0;
      end
      else
      begin
         irq_serviced <= 1'b0;
         // Only enabled pending requests are taken, never while held in reset
         if (irq_active != 6'h00 && !cpu_reset)
         begin
            wait_cnt <= (wait_cnt == 8'(DELAY)) ? 8'h00 : wait_cnt + 8'h01;
            irq_serviced <= (wait_cnt == 8'(DELAY));
         end
         else
            wait_cnt <= 8'h00;
      end
   end
endmodule

/* File: test/pwr_rst_props.sv */
// Concurrent checks on the power/reset controller's ports.
// Assumes one hclk domain and an active-low asynchronous hresetn.
`timescale 1ns/1ps
module pwr_rst_props #(
   parameter int unsigned POR_CYCLES = pwr_rst_pkg::POR_CYCLES
) (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        power_good,
   input wire logic        watchdog_timeout,
   input wire logic        stop_recovery_event,
   input wire logic        external_reset,
   input wire logic [5:0]  irq_in,
   input wire logic [5:0]  irq_enable,
   input wire logic        cpu_clk_en,
   input wire logic        timer_clk_en,
   input wire logic        crystal_oscillator_en,
   input wire logic        cpu_reset,
   input wire logic        load_restart_vector,
   input wire logic [15:0] restart_vector,
   input wire logic [5:0]  irq_active
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [31:0] rst_len;
   logic        ext_seen;
   wire         quiet = !watchdog_timeout && !stop_recovery_event && !external_reset && power_good;

   // External reset skips the timer unless it ends a stop with D5 set, so its short reset is exempt
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rst_len  <= 32'h0;
         ext_seen <= 1'b0;
      end
      else
      begin
         rst_len  <= cpu_reset ? rst_len + 32'h1 : 32'h0;
         // Held until the reset that the external request caused has ended
         ext_seen <= external_reset || (ext_seen && (cpu_reset || rst_len == 32'h0));
      end
   end

   sequence s_stopped;
      !crystal_oscillator_en && !$past(crystal_oscillator_en);
   endsequence
   sequence s_wake;
      !crystal_oscillator_en && stop_recovery_event;
   endsequence

   a_bus_okay_ready: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
   a_reset_gates_cpu: assert property (cpu_reset && $past(cpu_reset) |-> !cpu_clk_en)
      else $error("cpu clock runs in reset");
   a_stop_gates_clocks: assert property (s_stopped |-> !cpu_clk_en && !timer_clk_en)
      else $error("clock enable active in stop");
   a_stop_holds: assert property (!crystal_oscillator_en && quiet && $past(quiet) |=> !crystal_oscillator_en)
      else $error("stop left without a wake event");
   a_stop_wakes: assert property (s_wake |-> ##[1:3] crystal_oscillator_en)
      else $error("stop not left after recovery event");
   a_restart_vector: assert property (load_restart_vector |-> !cpu_reset
      && restart_vector == pwr_rst_pkg::STOP_RESTART_VECTOR)
      else $error("wrong restart vector");
   a_irq_mask_live: assert property (irq_active == ($past(irq_in) & $past(irq_enable)))
      else $error("irq_active does not follow masked inputs");
   a_timer_alive: assert property (crystal_oscillator_en && !cpu_reset |-> ##[0:16]
      (timer_clk_en || !crystal_oscillator_en || cpu_reset))
      else $error("timer enable missing");
   a_por_min_delay: assert property ($fell(cpu_reset) && !ext_seen |-> rst_len >= POR_CYCLES)
      else $error("reset released too early");
endmodule

bind pwr_rst_ctrl pwr_rst_props #(.POR_CYCLES(POR_CYCLES)) pwr_rst_props_inst (.hclk, .hresetn, .hreadyout,
   .hresp, .power_good, .watchdog_timeout, .stop_recovery_event, .external_reset, .irq_in, .irq_enable,
   .cpu_clk_en, .timer_clk_en, .crystal_oscillator_en, .cpu_reset, .load_restart_vector, .restart_vector,
   .irq_active);

/* File: test/pwr_rst_ctrl_tb_top.sv */
// Self-checking bench: AHB-Lite register access, irq source, halt, stop and reset timing.
// Assumes a zero-wait slave; the timer is shortened to POR cycles.
`timescale 1ns/1ps
module pwr_rst_ctrl_tb_top;
   localparam int POR = 20;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, power_good, watchdog_timeout;
   logic stop_recovery_event, external_reset, pin, irq_serviced, shared_irq, cpu_clk_en, timer_clk_en;
   logic crystal_oscillator_en, cpu_reset, load_restart_vector;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic [5:0]  irq_in, irq_enable, irq_active;
   logic [15:0] restart_vector;
   int          n_errors, tests_run, n, c, t;

   assign hready = hreadyout;

   pwr_rst_ctrl #(.POR_CYCLES(POR)) pwr_rst_ctrl_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .power_good, .watchdog_timeout,
      .stop_recovery_event, .external_reset, .port_three_bit_three_pin(pin), .irq_in, .irq_enable,
      .irq_serviced, .shared_irq, .cpu_clk_en, .timer_clk_en, .crystal_oscillator_en, .cpu_reset,
      .load_restart_vector, .restart_vector, .irq_active);
   core_model #(.DELAY(3)) core_model_inst (.hclk, .hresetn, .irq_active, .cpu_reset, .irq_serviced);

   initial
   begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Single word transfer; hold each phase until hready is seen high
   task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rdata);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr  <= a;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rdata = hrdata;
   endtask

   task wait_rst(input logic v, output int cnt);
      cnt = 0;
      while (cpu_reset !== v && cnt < 200)
      begin
         @(posedge hclk);
         cnt++;
      end
      chk({31'h0, cpu_reset === v}, 32'h1, "reset level");
   endtask

   // Sampled mid-cycle so registered enables are settled
   task count(input int cycles);
      c = 0;
      t = 0;
      repeat (cycles)
      begin
         @(negedge hclk);
         c += int'(cpu_clk_en === 1'b1);
         t += int'(timer_clk_en === 1'b1);
      end
      @(posedge hclk);
   endtask

   task pulse_wake();
      stop_recovery_event <= 1'b1;
      @(posedge hclk);
      stop_recovery_event <= 1'b0;
   endtask

   task test_done();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      #(20ns * 8000);
      n_errors++;
      $display("ERROR %0t: timeout", $time);
      test_done();
   end

   initial
   begin
      {hresetn, hsel, haddr, htrans, hwrite, hwdata, watchdog_timeout, stop_recovery_event} = '0;
      {external_reset, pin, irq_in, irq_enable} = '0;
      hsize = 3'b010;
      power_good = 1'b1;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      wait_rst(1'b0, n);
      chk({31'h0, n >= POR}, 32'h1, "power-on delay");
      bus(1'b0, pwr_rst_pkg::STOP_RECOVERY_ADDR, 32'h0, rd);
      chk(rd, 32'h20, "stop recovery reset value");
      bus(1'b0, pwr_rst_pkg::PORT_MODE_ADDR, 32'h0, rd);
      chk(rd, 32'h0, "port mode reset value");
      bus(1'b1, 12'hffc, 32'h5a, rd);
      bus(1'b0, 12'hffc, 32'h0, rd);
      chk(rd, 32'h0, "unmapped read");
      $display("test registers done");

      pin <= 1'b1;
      repeat (3) @(posedge hclk);
      chk(shared_irq, 1'b1, "digital source");
      bus(1'b1, pwr_rst_pkg::PORT_MODE_ADDR, 32'h2, rd);
      repeat (3) @(posedge hclk);
      chk(shared_irq, 1'b0, "analog ignores pin");
      pulse_wake();
      @(posedge hclk);
      chk(shared_irq, 1'b1, "analog source");
      pin <= 1'b0;
      $display("test irq source done");

      bus(1'b1, pwr_rst_pkg::STOP_RECOVERY_ADDR, 32'h21, rd);
      // Undivided enables still in flight from before the write
      repeat (2) @(posedge hclk);
      count(64);
      chk(c, 4, "divided cpu enable");
      chk(t, 4, "divided timer enable");
      irq_in <= 6'h04;
      bus(1'b1, pwr_rst_pkg::SLEEP_CMD_ADDR, 32'h1, rd);
      repeat (4) @(posedge hclk);
      count(64);
      chk(c, 0, "cpu clock in halt");
      chk(t, 4, "timer in halt");
      chk(crystal_oscillator_en, 1'b1, "oscillator in halt");
      bus(1'b0, pwr_rst_pkg::STATUS_ADDR, 32'h0, rd);
      chk(rd, 32'(pwr_rst_pkg::ST_HALT), "status in halt");
      irq_enable <= 6'h04;
      repeat (16) @(posedge hclk);
      count(64);
      chk(c, 4, "halt left after service");
      irq_in <= 6'h00;
      irq_enable <= 6'h00;
      $display("test halt done");

      bus(1'b1, pwr_rst_pkg::STOP_RECOVERY_ADDR, 32'h01, rd);
      bus(1'b1, pwr_rst_pkg::SLEEP_CMD_ADDR, 32'h2, rd);
      repeat (24) @(posedge hclk);
      chk(crystal_oscillator_en, 1'b0, "oscillator in stop");
      pulse_wake();
      n = 0;
      while (load_restart_vector !== 1'b1 && n < 20)
      begin
         @(posedge hclk);
         n++;
      end
      chk(load_restart_vector, 1'b1, "restart load");
      chk(restart_vector, 16'h000c, "restart vector");
      chk(cpu_reset, 1'b0, "timer bypassed");
      bus(1'b0, pwr_rst_pkg::STOP_RECOVERY_ADDR, 32'h0, rd);
      chk(rd, 32'h0, "divide bit cleared");
      $display("test stop bypass done");

      bus(1'b1, pwr_rst_pkg::STOP_RECOVERY_ADDR, 32'h20, rd);
      bus(1'b1, pwr_rst_pkg::SLEEP_CMD_ADDR, 32'h2, rd);
      repeat (4) @(posedge hclk);
      pulse_wake();
      wait_rst(1'b1, n);
      wait_rst(1'b0, n);
      chk({31'h0, n >= POR}, 32'h1, "delay after stop");
      watchdog_timeout <= 1'b1;
      @(posedge hclk);
      watchdog_timeout <= 1'b0;
      wait_rst(1'b1, n);
      wait_rst(1'b0, n);
      chk({31'h0, n >= POR}, 32'h1, "delay after watchdog");
      bus(1'b1, pwr_rst_pkg::SLEEP_CMD_ADDR, 32'h2, rd);
      repeat (4) @(posedge hclk);
      chk(crystal_oscillator_en, 1'b0, "oscillator in second stop");
      external_reset <= 1'b1;
      @(posedge hclk);
      external_reset <= 1'b0;
      wait_rst(1'b1, n);
      wait_rst(1'b0, n);
      chk(crystal_oscillator_en, 1'b1, "stop left by external reset");
      bus(1'b0, pwr_rst_pkg::STATUS_ADDR, 32'h0, rd);
      chk(rd, 32'(pwr_rst_pkg::ST_RUN), "status in run");
      $display("test reset timer done");
      test_done();
   end
endmodule
